// ### cfl_assertions.sv
`timescale 1ns/1ps
module cfl_assertions (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic bit_tick,
    input wire logic tx_err_evt,
    input wire logic rx_err_evt,
    input wire logic tx_done_evt,
    input wire logic error_flag_req,
    input wire logic error_flag_active,
    input wire logic tx_suspend,
    input wire logic tx_enable,
    input wire logic rx_enable,
    input wire logic mailbox_enable,
    input wire logic bus_drive_en
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic [3:0] ticks;
    // bit count since reset, saturating so it never wraps back below a run
    always_ff @(posedge clk_sys) begin
        if (!rst_b)
            ticks <= 4'h0;
        else if (bit_tick && ticks != 4'hF)
            ticks <= ticks + 4'h1;
    end
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_err_cause: assert property (error_flag_req |-> tx_err_evt || rx_err_evt)
        else $error("error flag without a detected error");
    a_err_online: assert property ((tx_err_evt || rx_err_evt) && bus_drive_en
        |-> error_flag_req) else $error("online node missed error flag");
    a_off_silent: assert property (!bus_drive_en |-> !error_flag_req && !tx_enable)
        else $error("node acts on bus while not driving");
    a_suspend_cause: assert property (tx_suspend |-> tx_done_evt && !error_flag_active)
        else $error("suspend without passive transmit end");
    a_passive_wait: assert property (tx_done_evt && !error_flag_active && bus_drive_en
        |-> tx_suspend) else $error("passive node skipped suspend");
    a_lp_quiet: assert property (!mailbox_enable |-> !tx_enable && !rx_enable)
        else $error("traffic enabled with mailboxes off");
    a_sync_first: assert property (rx_enable |-> ticks >= 4'hB)
        else $error("receive enabled before recessive run");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read not answered");
endmodule : cfl_assertions
bind cfl_top cfl_assertions chk (.clk_sys, .rst_b, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .bit_tick, .tx_err_evt, .rx_err_evt, .tx_done_evt,
    .error_flag_req, .error_flag_active, .tx_suspend, .tx_enable, .rx_enable,
    .mailbox_enable, .bus_drive_en);

// ### cfl_bus_model.sv
`timescale 1ns/1ps
module cfl_bus_model (
    input wire logic clk_sys,
    input wire logic dom,
    output logic bus_rx,
    output logic bit_tick
);
    logic [1:0] phase = 2'h0;
    // one bit per four system clocks keeps the bus-off recovery run short
    always_ff @(posedge clk_sys) begin
        phase <= phase + 2'h1;
        bit_tick <= (phase == 2'h3);
    end
    // the line has a pull-up, so a released bus reads recessive
    assign bus_rx = !dom;
endmodule : cfl_bus_model

// ### cfl_pkg.sv
// Operation
// - error active: join traffic, send active error flag on any detected error.
// - error passive: only passive error flags; suspend wait after own transmission.
// - bus off: never drive the bus lines.
// - keep transmit and receive error counters, software readable; state follows them.
// - flags: active 1/0/0, passive 0/1/0, bus off 0/1/1.
// - each state flag interrupt pends while flag set and its mask enables.
// - warning flag when either counter exceeds 96, still error active.
// - state and warning flags are not latched, decoded from counters; the code holds the bus off flag in bus_off_latch.
// - leave bus off only after 128 runs of 11 recessive bits, or reset.
// - reactive overload on intermission, last eof or delimiter dominant bits.
// - with overload enable set, request overload after each mailbox delivery.
// - reactive overload regardless of enable; overload leaves counters alone.
// - in low power no transmit, no receive, mailboxes inactive.
// - sleep set in low power, wake otherwise, exclusive; both 0 after reset.
// - after reset low power off; wake only after 11 recessive bits.
// - low power request enters low power after pending transmits, sets sleep.
// - reception off while sleep set; allowed between request and entry.
// - error counters frozen while sleep set; the code still clears them when bus off ends during sleep.
// - exit: clear request, resync on eleven recessive bits, set wake.
// - idle bus: transmit eleven bits after exit; busy bus: resync next interframe; the code wakes at the next run end, 1 to 11 bits after exit.
package cfl_pkg;
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_ECR = 4'hC;
    localparam int MODE_OVL_BIT = 0;
    localparam int MODE_LPM_BIT = 1;
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_WARN_BIT = 1;
    localparam int ST_PASSIVE_BIT = 2;
    localparam int ST_BUS_OFF_FLAG_BIT = 3;
    localparam int ST_SLEEP_BIT = 4;
    localparam int ST_WAKE_BIT = 5;
    localparam int ECR_TEC_POS = 16;
    localparam logic [8:0] WARN_LIMIT = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
    localparam logic [8:0] BUS_OFF_FLAG_LIMIT = 9'h0FF;
    localparam logic [3:0] RECESSIVE_RUN = 4'hB;
    localparam logic [7:0] BUS_OFF_FLAG_RUNS = 8'h80;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        LP_AWAKE = 3'b001,
        LP_DRAIN = 3'b010,
        LP_SLEEP = 3'b100
    } cfl_lp_e;
endpackage : cfl_pkg

// ### cfl_top.sv
`timescale 1ns/1ps
module cfl_top
    import cfl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic bus_rx,
    input wire logic bit_tick,
    input wire logic tx_err_evt,
    input wire logic rx_err_evt,
    input wire logic tx_ok_evt,
    input wire logic rx_ok_evt,
    input wire logic tx_done_evt,
    input wire logic dom_intermission_evt,
    input wire logic dom_last_eof_rx_evt,
    input wire logic dom_delim_evt,
    input wire logic mailbox_deliver_evt,
    input wire logic tx_pending,
    input wire logic frame_busy,
    output logic error_flag_req,
    output logic error_flag_active,
    output logic overload_req,
    output logic tx_suspend,
    output logic tx_enable,
    output logic rx_enable,
    output logic mailbox_enable,
    output logic bus_drive_en,
    output logic irq_status
);
    // bus pin passes three flops; second and third must agree
    logic [2:0] rx_sync;
    logic rx_level;
    logic [8:0] transmit_error_count;
    logic [8:0] receive_error_count;
    logic [31:0] can_mode_reg;
    logic [31:0] interrupt_mask_status_reg;
    logic [3:0] rec_run;
    logic [7:0] bus_off_flag_runs;
    logic bus_off_latch;
    logic synced;
    logic sleep_flag;
    logic wake_flag;
    cfl_lp_e lp_state;
    cfl_lp_e next_lp_state;
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rx_sync <= 3'h7;
            rx_level <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], bus_rx};
            if (rx_sync[1] == rx_sync[2])
                rx_level <= rx_sync[2];
        end
    end

    // state decode straight from the counters; bus off comes from the stored bus_off_latch
    wire logic bus_off_flag_st = bus_off_latch;
    wire logic passive_st = !bus_off_flag_st && ((transmit_error_count > PASSIVE_LIMIT)
        || (receive_error_count > PASSIVE_LIMIT));
    wire logic error_active_flag = !bus_off_flag_st && !passive_st;
    wire logic error_passive_flag = passive_st || bus_off_flag_st;
    wire logic bus_off_flag = bus_off_flag_st;
    wire logic warn_flag = error_active_flag
        && ((transmit_error_count > WARN_LIMIT)
        || (receive_error_count > WARN_LIMIT));

    // counters frozen in sleep except for the bus-off recovery clear; overload flags never reach them
    wire logic cnt_run = !sleep_flag;
    wire logic [8:0] tec_inc = (transmit_error_count > 9'h1F7) ? 9'h1FF
        : 9'(transmit_error_count + 9'h008);
    wire logic [8:0] rec_inc = (receive_error_count >= PASSIVE_LIMIT)
        ? receive_error_count : 9'(receive_error_count + 9'h001);
    wire logic bit_recessive = bit_tick && rx_level;
    wire logic run_done = bit_recessive && (rec_run == 4'(RECESSIVE_RUN - 4'h1));

    // error counters and bus-off recovery tally
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            transmit_error_count <= 9'h000;
            receive_error_count <= 9'h000;
            bus_off_latch <= 1'b0;
            bus_off_flag_runs <= 8'h00;
        end else if (bus_off_latch) begin
            // 128 runs of eleven recessive bits end bus off
            if (run_done) begin
                if (bus_off_flag_runs == 8'(BUS_OFF_FLAG_RUNS - 8'h01)) begin
                    bus_off_latch <= 1'b0;
                    bus_off_flag_runs <= 8'h00;
                    transmit_error_count <= 9'h000;
                    receive_error_count <= 9'h000;
                end else begin
                    bus_off_flag_runs <= 8'(bus_off_flag_runs + 8'h01);
                end
            end
        end else if (cnt_run) begin
            if (tx_err_evt) begin
                transmit_error_count <= tec_inc;
                if (transmit_error_count > 9'h0F7)
                    bus_off_latch <= 1'b1;
            end else if (tx_ok_evt && transmit_error_count != 9'h000) begin
                transmit_error_count <= 9'(transmit_error_count - 9'h001);
            end
            if (rx_err_evt)
                receive_error_count <= rec_inc;
            else if (rx_ok_evt && receive_error_count != 9'h000)
                receive_error_count <= 9'(receive_error_count - 9'h001);
        end
    end

    // recessive run counter; any dominant bit restarts it
    always_ff @(posedge clk_sys) begin
        if (!rst_b)
            rec_run <= 4'h0;
        else if (bit_tick)
            rec_run <= (!rx_level || run_done) ? 4'h0 : 4'(rec_run + 4'h1);
    end

    // low-power sequencing
    always_comb begin
        next_lp_state = lp_state;
        case (lp_state)
            LP_AWAKE: if (can_mode_reg[MODE_LPM_BIT])
                next_lp_state = LP_DRAIN;
            LP_DRAIN: begin
                if (!can_mode_reg[MODE_LPM_BIT])
                    next_lp_state = LP_AWAKE;
                else if (!tx_pending && !frame_busy)
                    next_lp_state = LP_SLEEP;
            end
            LP_SLEEP: if (!can_mode_reg[MODE_LPM_BIT])
                next_lp_state = LP_AWAKE;
            default: next_lp_state = LP_AWAKE;
        endcase
    end

    // wake needs a fresh eleven-bit recessive run after reset; after sleep, the next run end, with bits counted during sleep;
    // a busy bus simply delays that run to the next interframe
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            lp_state <= LP_AWAKE;
            synced <= 1'b0;
            sleep_flag <= 1'b0;
            wake_flag <= 1'b0;
        end else begin
            lp_state <= next_lp_state;
            if (next_lp_state == LP_SLEEP) begin
                sleep_flag <= 1'b1;
                wake_flag <= 1'b0;
                synced <= 1'b0;
            end else if (lp_state == LP_SLEEP) begin
                synced <= 1'b0;
            end else if (!synced && run_done) begin
                synced <= 1'b1;
                wake_flag <= 1'b1;
                sleep_flag <= 1'b0;
            end
        end
    end

    // bus participation
    wire logic in_lp = (lp_state == LP_SLEEP);
    wire logic online = synced && !in_lp && !bus_off_flag;
    assign tx_enable = online;
    assign rx_enable = online && !sleep_flag;
    assign mailbox_enable = !in_lp;
    assign bus_drive_en = online;
    assign error_flag_req = online && (tx_err_evt || rx_err_evt);
    assign error_flag_active = error_active_flag;
    // passive node waits after each own transmission
    assign tx_suspend = error_passive_flag && tx_done_evt;
    // reactive whenever online, request overload only with enable
    assign overload_req = online && (dom_intermission_evt
        || dom_last_eof_rx_evt || dom_delim_evt
        || (can_mode_reg[MODE_OVL_BIT] && mailbox_deliver_evt));

    // status word and level interrupt; software masks each source, any enabled one raises it
    wire logic [31:0] status_word = {26'h0, wake_flag, sleep_flag, bus_off_flag,
        error_passive_flag, warn_flag, error_active_flag};
    assign irq_status = |(status_word & interrupt_mask_status_reg);
    wire logic [31:0] error_counter_reg = {7'h0, transmit_error_count,
        7'h0, receive_error_count};

    // axi-lite write: address and data in either order
    wire logic wr_go = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    wire logic wr_mode = wr_go && aw_addr == ADDR_MODE;
    wire logic wr_mask = wr_go && aw_addr == ADDR_MASK;
    wire logic wr_known = wr_mode || wr_mask;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // byte-lane merge for writable registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
        input logic [31:0] val, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[i*8 +: 8] = val[i*8 +: 8];
        return res;
    endfunction : lane_merge

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            can_mode_reg <= MODE_RESET;
            interrupt_mask_status_reg <= MASK_RESET;
        end else begin
            if (wr_mode)
                can_mode_reg <= lane_merge(can_mode_reg, w_data, w_strb) & 32'h3;
            if (wr_mask)
                interrupt_mask_status_reg <= lane_merge(
                    interrupt_mask_status_reg, w_data, w_strb) & 32'h3F;
        end
    end

    // axi-lite read; one word answered the edge after address
    wire logic rd_ok = s_axi_araddr == ADDR_MODE || s_axi_araddr == ADDR_MASK
        || s_axi_araddr == ADDR_STATUS || s_axi_araddr == ADDR_ECR;
    wire logic [31:0] rd_word = (s_axi_araddr == ADDR_MODE) ? can_mode_reg
        : (s_axi_araddr == ADDR_MASK) ? interrupt_mask_status_reg
        : (s_axi_araddr == ADDR_STATUS) ? status_word
        : (s_axi_araddr == ADDR_ECR) ? error_counter_reg : 32'h0;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : cfl_top

// ### cfl_top_tb.sv
`timescale 1ns/1ps
module cfl_top_tb import cfl_pkg::*;;
    logic clk_sys = 1'b0, rst_b = 1'b0, dom = 1'b0, bus_rx, bit_tick;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tx_pending = 1'b0, frame_busy = 1'b0, tx_suspend, irq_status;
    logic [8:0] ev = 9'h000;
    logic [3:0] seen;
    logic error_flag_req, error_flag_active, overload_req, tx_enable;
    logic rx_enable, mailbox_enable, bus_drive_en;
    int n_mismatch = 0, cmp_count = 0;
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    cfl_bus_model bus (.clk_sys, .dom, .bus_rx, .bit_tick);
    cfl_top dut (.*, .tx_err_evt(ev[0]), .rx_err_evt(ev[1]), .tx_ok_evt(ev[2]),
        .rx_ok_evt(ev[3]), .tx_done_evt(ev[4]), .dom_intermission_evt(ev[5]),
        .dom_last_eof_rx_evt(ev[6]), .dom_delim_evt(ev[7]),
        .mailbox_deliver_evt(ev[8]));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // handshakes are judged at the rising edge with the values that edge sees;
    // each channel is released only once its own valid and ready met there
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic b;
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        b = 1'b0;
        for (int n = 0; n < 50 && !b; n++) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                b = 1'b1;
                rr = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        if (!b) n_mismatch++;
    endtask : wr
    task rd(input logic [3:0] a);
        logic b;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        b = 1'b0;
        for (int n = 0; n < 50 && !b; n++) begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                b = 1'b1;
                rv = s_axi_rdata;
                rr = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
        if (!b) n_mismatch++;
    endtask : rd
    task rchk(input logic [3:0] a, input logic [31:0] exp);
        rd(a);
        chk(rv, exp);
    endtask : rchk
    // one-cycle event pulse; the combinational answers are caught mid-cycle
    task fire(input logic [8:0] e);
        @(posedge clk_sys);
        ev <= e;
        @(negedge clk_sys);
        seen = {tx_suspend, error_flag_active, error_flag_req, overload_req};
        @(posedge clk_sys);
        ev <= 9'h000;
    endtask : fire
    task pulse(input int idx, input int n);
        repeat (n) fire(9'h001 << idx);
    endtask : pulse
    task bits(input int n);
        repeat (4 * n) @(posedge clk_sys);
    endtask : bits
    task t_reset;
        rchk(ADDR_STATUS, 32'h0000_0001);
        rchk(ADDR_ECR, 32'h0000_0000);
        chk(tx_enable, 32'h0);
        wr(ADDR_STATUS, 32'h0000_00FF);
        chk(rr, RESP_SLVERR);
        bits(16);
        rchk(ADDR_STATUS, 32'h0000_0021);
        $display("reset and sync test done");
    endtask : t_reset
    task t_errors;
        fire(9'h001);
        chk(seen, 32'h6);
        pulse(0, 12);
        rchk(ADDR_ECR, 32'h0068_0000);
        rchk(ADDR_STATUS, 32'h0000_0023);
        pulse(0, 3);
        rchk(ADDR_STATUS, 32'h0000_0024);
        fire(9'h012);
        chk(seen, 32'hA);
        rchk(ADDR_ECR, 32'h0080_0001);
        pulse(3, 1);
        pulse(2, 1);
        rchk(ADDR_STATUS, 32'h0000_0023);
        pulse(0, 16);
        rchk(ADDR_STATUS, 32'h0000_0024);
        pulse(0, 1);
        rchk(ADDR_ECR, 32'h0107_0000);
        rd(ADDR_STATUS);
        chk(rv & 32'hF, 32'hC);
        chk(bus_drive_en, 32'h0);
        bits(1100);
        rd(ADDR_STATUS);
        chk(rv & 32'hF, 32'hC);
        bits(400);
        rd(ADDR_STATUS);
        chk(rv & 32'hF, 32'h1);
        $display("fault confinement test done");
    endtask : t_errors
    task t_ovl_irq;
        fire(9'h100);
        chk(seen[0], 32'h0);
        wr(ADDR_MODE, 32'h0000_0001);
        fire(9'h100);
        chk(seen[0], 32'h1);
        wr(ADDR_MODE, 32'h0000_0000);
        for (int i = 5; i < 8; i++) begin
            fire(9'h001 << i);
            chk(seen[0], 32'h1);
        end
        rchk(ADDR_ECR, 32'h0000_0000);
        wr(ADDR_MASK, 32'h0000_0001);
        @(negedge clk_sys);
        chk(irq_status, 32'h1);
        wr(ADDR_MASK, 32'h0000_0008);
        @(negedge clk_sys);
        chk(irq_status, 32'h0);
        $display("overload and interrupt test done");
    endtask : t_ovl_irq
    task t_lowpower;
        @(posedge clk_sys);
        tx_pending <= 1'b1;
        wr(ADDR_MODE, 32'h0000_0002);
        bits(4);
        rd(ADDR_STATUS);
        chk(rv & 32'h1F, 32'h01);
        {tx_pending, frame_busy} <= 2'b01;
        bits(4);
        rd(ADDR_STATUS);
        chk(rv & 32'h1F, 32'h01);
        frame_busy <= 1'b0;
        bits(4);
        rchk(ADDR_STATUS, 32'h0000_0011);
        chk(mailbox_enable, 32'h0);
        chk(rx_enable, 32'h0);
        pulse(0, 2);
        rchk(ADDR_ECR, 32'h0000_0000);
        dom <= 1'b1;
        wr(ADDR_MODE, 32'h0000_0000);
        bits(20);
        rchk(ADDR_STATUS, 32'h0000_0011);
        dom <= 1'b0;
        bits(16);
        rchk(ADDR_STATUS, 32'h0000_0021);
        chk(tx_enable, 32'h1);
        chk(rx_enable, 32'h1);
        $display("low power test done");
    endtask : t_lowpower
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_errors();
        t_ovl_irq();
        t_lowpower();
        conclude();
    end
    // the whole run needs about 32 us; a hang is cut well after that
    initial begin
        #150000;
        n_mismatch++;
        conclude();
    end
endmodule : cfl_top_tb
